// *** verilog/fwsr_pkg.sv ***
// Package for the flash status polling controller
package fwsr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_DATA   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ    = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  localparam logic [7:0] OFF_RESULT = 8'h18;

  // Control bit positions
  localparam int CTRL_POLL  = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_READ  = 2;
  localparam int CTRL_RESET = 3;

  // Interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_BUS  = 2;

  // Flash data bit positions
  localparam int BIT_POLL    = 7;
  localparam int BIT_TOGGLE  = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_WINDOW  = 3;
  localparam int BIT_SECTOR  = 2;

  // Reset values
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [15:0] RESET_CMD = 16'h00F0;

  // Bus cycle timing
  localparam int CLK_NS      = 50;
  localparam int ACCESS_NS   = 100;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS  = 50;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;

  // Poll outcome codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_OK   = 2'h1;
  localparam logic [1:0] RES_FAIL = 2'h2;

  typedef struct packed {
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic [19:0] addr;
  } fwsr_pins_type;

  typedef enum logic [1:0] {
    FWSR_OP_READ  = 2'b01,
    FWSR_OP_WRITE = 2'b10
  } fwsr_op_type;

endpackage : fwsr_pkg

// *** verilog/fwsr_cycle.sv ***
// One asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module fwsr_cycle (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // Request
  input  wire logic                   start,
  input  wire fwsr_pkg::fwsr_op_type  op,
  input  wire logic [19:0]            addr,
  input  wire logic [15:0]            wdata,
  output logic                        done,
  output logic [15:0]                 rdata,
  // Flash pins
  output fwsr_pkg::fwsr_pins_type     pins,
  output logic [15:0]                 dqOut,
  output logic                        dqOe,
  input  wire logic [15:0]            dqSync
);

  typedef enum logic [2:0] {
    C_IDLE   = 3'b001,
    C_STROBE = 3'b010,
    C_REC    = 3'b100
  } fwsr_cyc_type;

  fwsr_cyc_type state;
  logic [3:0]   count;
  logic         isWrite;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state   <= C_IDLE;
      count   <= 4'h0;
      isWrite <= 1'b0;
      pins    <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: 20'h0_0000};
      dqOut   <= 16'h0000;
      dqOe    <= 1'b0;
      rdata   <= 16'h0000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        C_IDLE: begin
          if (start) begin
            isWrite   <= (op == fwsr_pkg::FWSR_OP_WRITE);
            pins.addr <= addr;
            pins.ceN  <= 1'b0;
            pins.oeN  <= (op == fwsr_pkg::FWSR_OP_WRITE);
            pins.weN  <= (op != fwsr_pkg::FWSR_OP_WRITE);
            dqOut     <= wdata;
            dqOe      <= (op == fwsr_pkg::FWSR_OP_WRITE);
            count     <= 4'(fwsr_pkg::ACCESS_CYC + 2);
            state     <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (count == 4'h0) begin
            if (!isWrite) rdata <= dqSync;
            pins.ceN <= 1'b1;
            pins.oeN <= 1'b1;
            pins.weN <= 1'b1;
            count    <= 4'(fwsr_pkg::RECOVER_CYC);
            state    <= C_REC;
          end else begin
            count <= count - 4'h1;
          end
        end
        C_REC: begin
          if (count == 4'h0) begin
            dqOe  <= 1'b0;
            done  <= 1'b1;
            state <= C_IDLE;
          end else begin
            count <= count - 4'h1;
          end
        end
      endcase
    end
  end

endmodule : fwsr_cycle

// *** verilog/fwsr_host.sv ***
// Flash status polling controller with AXI4-Lite registers
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module fwsr_host (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // AXI4-Lite write address and data
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [7:0]            awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  // AXI4-Lite write response
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  // AXI4-Lite read
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [7:0]            araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  // Flash pins
  output fwsr_pkg::fwsr_pins_type    flashPins,
  output logic [15:0]                dqOut,
  output logic                       dqOe,
  input  wire logic [15:0]           dqIn,
  input  wire logic                  readyBusy,
  // Interrupt
  output logic                       irq
);

  typedef enum logic [7:0] {
    S_IDLE   = 8'b0000_0001,
    S_READA  = 8'b0000_0010,
    S_READB  = 8'b0000_0100,
    S_CHECK  = 8'b0000_1000,
    S_RETEST = 8'b0001_0000,
    S_FINAL  = 8'b0010_0000,
    S_RESET  = 8'b0100_0000,
    S_SINGLE = 8'b1000_0000
  } fwsr_state_type;

  fwsr_state_type state;
  logic [19:0]    addrReg;
  logic [15:0]    dataReg;
  logic [15:0]    firstRead;
  logic [1:0]     result;
  logic [31:0]    irqStatus;
  logic [31:0]    irqMask;
  logic           cycStart;
  fwsr_pkg::fwsr_op_type cycOp;
  logic           cycDone;
  logic [15:0]    cycData;
  logic [15:0]    dqMeta;
  logic [15:0]    dqSync;
  logic           rbMeta;
  logic           rbSync;
  logic           awHeld;
  logic           wHeld;
  logic [7:0]     awAddrHeld;
  logic [31:0]    wDataHeld;
  logic [3:0]     wStrbHeld;
  logic           wrFire;
  logic           cmdPoll;
  logic           cmdWrite;
  logic           cmdRead;
  logic           cmdReset;
  logic           togglingAB;
  logic           evDone;
  logic           evFail;
  logic           evBus;
  logic           cycBusy;
  logic           singleWrite;
  logic [31:0]    irqSet;

  // Pin synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dqMeta <= 16'h0000;
      dqSync <= 16'h0000;
      rbMeta <= 1'b1;
      rbSync <= 1'b1;
    end else begin
      dqMeta <= dqIn;
      dqSync <= dqMeta;
      rbMeta <= readyBusy;
      rbSync <= rbMeta;
    end
  end

  fwsr_cycle uCycle (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (cycStart),
    .op     (cycOp),
    .addr   (addrReg),
    .wdata  (state == S_RESET ? fwsr_pkg::RESET_CMD : dataReg),
    .done   (cycDone),
    .rdata  (cycData),
    .pins   (flashPins),
    .dqOut  (dqOut),
    .dqOe   (dqOe),
    .dqSync (dqSync)
  );

  // AXI write channel capture
  assign awready = !awHeld;
  assign wready  = !wHeld;
  assign wrFire  = awHeld && wHeld && !bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld  <= 32'h0000_0000;
      wStrbHeld  <= 4'h0;
      bvalid     <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld     <= 1'b1;
        awAddrHeld <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld     <= 1'b1;
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  assign bresp = 2'b00;

  // Commands accepted only while idle
  assign cmdPoll  = wrFire && awAddrHeld == fwsr_pkg::OFF_CTRL && wStrbHeld[0]
                    && wDataHeld[fwsr_pkg::CTRL_POLL] && state == S_IDLE;
  assign cmdWrite = wrFire && awAddrHeld == fwsr_pkg::OFF_CTRL && wStrbHeld[0]
                    && wDataHeld[fwsr_pkg::CTRL_WRITE] && state == S_IDLE;
  assign cmdRead  = wrFire && awAddrHeld == fwsr_pkg::OFF_CTRL && wStrbHeld[0]
                    && wDataHeld[fwsr_pkg::CTRL_READ] && state == S_IDLE;
  assign cmdReset = wrFire && awAddrHeld == fwsr_pkg::OFF_CTRL && wStrbHeld[0]
                    && wDataHeld[fwsr_pkg::CTRL_RESET] && state == S_IDLE;

  // Address and data registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrReg <= 20'h0_0000;
      dataReg <= 16'h0000;
    end else begin
      if (wrFire && awAddrHeld == fwsr_pkg::OFF_ADDR && state == S_IDLE) begin
        addrReg <= wDataHeld[19:0];
      end
      if (wrFire && awAddrHeld == fwsr_pkg::OFF_DATA && state == S_IDLE) begin
        dataReg <= wDataHeld[15:0];
      end
      if (state == S_SINGLE && cycDone && cycOp == fwsr_pkg::FWSR_OP_READ) begin
        dataReg <= cycData;
      end
      if (state == S_FINAL && cycDone) begin
        dataReg <= cycData;
      end
    end
  end

  assign togglingAB = firstRead[fwsr_pkg::BIT_TOGGLE] != cycData[fwsr_pkg::BIT_TOGGLE];
  assign cycStart   = (state != S_IDLE) && !cycDone && !cycBusy;

  // Polling sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= S_IDLE;
      firstRead   <= 16'h0000;
      result      <= fwsr_pkg::RES_NONE;
      cycBusy     <= 1'b0;
      singleWrite <= 1'b0;
    end else begin
      if (cycStart) cycBusy <= 1'b1;
      if (cycDone) cycBusy <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (cmdPoll) begin
            result <= fwsr_pkg::RES_NONE;
            state  <= S_READA;
          end else if (cmdWrite || cmdRead) begin
            singleWrite <= cmdWrite;
            state       <= S_SINGLE;
          end else if (cmdReset) begin
            state <= S_RESET;
          end
        end
        S_READA: begin
          if (cycDone) begin
            firstRead <= cycData;
            state     <= S_READB;
          end
        end
        S_READB: begin
          if (cycDone) begin
            if (!togglingAB) begin
              state <= S_FINAL;
            end else if (cycData[fwsr_pkg::BIT_TIMEOUT]) begin
              firstRead <= cycData;
              state     <= S_RETEST;
            end else begin
              firstRead <= cycData;
              state     <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          if (cycDone) begin
            if (!togglingAB) begin
              state <= S_FINAL;
            end else if (cycData[fwsr_pkg::BIT_TIMEOUT]) begin
              firstRead <= cycData;
              state     <= S_RETEST;
            end else begin
              firstRead <= cycData;
            end
          end
        end
        S_RETEST: begin
          if (cycDone) begin
            if (!togglingAB) begin
              state <= S_FINAL;
            end else begin
              result <= fwsr_pkg::RES_FAIL;
              state  <= S_RESET;
            end
          end
        end
        S_FINAL: begin
          if (cycDone) begin
            result <= fwsr_pkg::RES_OK;
            state  <= S_IDLE;
          end
        end
        S_RESET: begin
          if (cycDone) state <= S_IDLE;
        end
        S_SINGLE: begin
          if (cycDone) state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign cycOp = (state == S_RESET || (state == S_SINGLE && singleWrite))
                 ? fwsr_pkg::FWSR_OP_WRITE : fwsr_pkg::FWSR_OP_READ;

  // Interrupt events
  assign evDone = state == S_FINAL && cycDone;
  assign evFail = state == S_RETEST && cycDone && togglingAB;
  assign evBus  = state == S_SINGLE && cycDone;

  // Event set vector
  always_comb begin
    irqSet                     = 32'h0000_0000;
    irqSet[fwsr_pkg::IRQ_DONE] = evDone;
    irqSet[fwsr_pkg::IRQ_FAIL] = evFail;
    irqSet[fwsr_pkg::IRQ_BUS]  = evBus;
  end

  // Interrupt mask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= fwsr_pkg::RST_MASK;
    end else if (wrFire && awAddrHeld == fwsr_pkg::OFF_MASK) begin
      irqMask <= wDataHeld;
    end
  end

  // Sticky status bits, set wins over clear
  for (genvar i = 0; i < 32; i++) begin : gIrq
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        irqStatus[i] <= 1'b0;
      end else if (irqSet[i]) begin
        irqStatus[i] <= 1'b1;
      end else if (wrFire && awAddrHeld == fwsr_pkg::OFF_IRQ && wDataHeld[i]) begin
        irqStatus[i] <= 1'b0;
      end
    end
  end
  assign irq = |(irqStatus & irqMask);

  // AXI read channel
  assign arready = !rvalid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= 2'b00;
      unique case (araddr)
        fwsr_pkg::OFF_CTRL:   rdata <= {31'h0, state != S_IDLE};
        fwsr_pkg::OFF_ADDR:   rdata <= {12'h000, addrReg};
        fwsr_pkg::OFF_DATA:   rdata <= {16'h0000, dataReg};
        fwsr_pkg::OFF_STATUS: rdata <= {15'h0000, rbSync, firstRead};
        fwsr_pkg::OFF_IRQ:    rdata <= irqStatus;
        fwsr_pkg::OFF_MASK:   rdata <= irqMask;
        fwsr_pkg::OFF_RESULT: rdata <= {30'h0, result};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= 2'b10;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : fwsr_host

// *** bench/fwsr_host_sva.sv ***
// Assertion checker for the flash status polling controller
`timescale 1ns/1ps
module fwsr_host_sva (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rst_n,
  // Bus answers
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [31:0]             rdata,
  // Flash pins
  input wire fwsr_pkg::fwsr_pins_type flashPins,
  input wire logic                    dqOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_bresp_okay: assert property (bvalid |-> bresp == 2'h0)
    else $error("write answer not okay");
  a_bvalid_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed");
  a_read_answer: assert property ($rose(rvalid) |-> $past(arvalid && arready))
    else $error("read answer without request");
  a_read_frame: assert property (
    $fell(flashPins.oeN) |-> !flashPins.oeN [*4] ##[1:2] flashPins.oeN)
    else $error("read strobe length wrong");
  a_read_recover: assert property ($rose(flashPins.oeN) |-> flashPins.oeN [*2])
    else $error("read recovery too short");
  a_no_contention: assert property (!flashPins.oeN |-> !dqOe)
    else $error("data driven during read");
  a_strobe_excl: assert property (!(!flashPins.oeN && !flashPins.weN))
    else $error("read and write strobes together");
  a_write_drive: assert property (!flashPins.weN |-> dqOe)
    else $error("write strobe without data");
  a_addr_steady: assert property (
    !flashPins.oeN && $past(!flashPins.oeN) |-> $stable(flashPins.addr))
    else $error("address moved in a read");
endmodule : fwsr_host_sva

// *** bench/fwsr_flash_model.sv ***
// Behavioural flash device answering status polls
`timescale 1ns/1ps
module fwsr_flash_model #(parameter logic [15:0] PGM_WORD = 16'h00A5) (
  // Host pins
  input  wire fwsr_pkg::fwsr_pins_type pins,
  input  wire logic [15:0]             dqOut,
  input  wire logic                    dqOe,
  output logic [15:0]                  dqIn,
  output logic                         readyBusy,
  // Scenario control
  input  wire logic                    arm,
  input  wire logic [7:0]              opReads,
  input  wire logic                    opFail,
  input  wire logic                    opErase,
  output logic [7:0]                   readCount,
  output logic [7:0]                   resetSeen,
  output logic [15:0]                  lastWrite
);
  logic       busy, toggle, failing, erasing;
  logic [7:0] busyLeft;
  logic [15:0] lastOut, word;
  initial begin
    {busy, toggle, failing, erasing} = 4'h0;
    {busyLeft, readCount, resetSeen} = 24'h0;
    {lastWrite, lastOut} = 32'h0;
  end
  always @(posedge arm) begin
    busy = (opReads != 8'h00) || opFail;
    busyLeft = opReads;
    failing = opFail;
    erasing = opErase;
    toggle = 1'b0;
    readCount = 8'h00;
  end
  // End of each read cycle
  always @(posedge pins.oeN) if (pins.weN) begin
    readCount = readCount + 8'h01;
    lastOut = word;
    if (busy) begin
      toggle = ~toggle;
      if (busyLeft != 8'h00) busyLeft = busyLeft - 8'h01;
      if (busyLeft == 8'h00 && !failing) busy = 1'b0;
    end
  end
  // Reset command returns a failed device to array data
  always @(posedge pins.weN) begin
    lastWrite = dqOut;
    if (dqOut == fwsr_pkg::RESET_CMD) begin
      resetSeen = resetSeen + 8'h01;
      if (failing) begin busy = 1'b0; failing = 1'b0; end
    end
  end
  // Erase word: poll bit 0, window bit 1 after the acceptance read
  assign word = !busy ? PGM_WORD
              : erasing ? {PGM_WORD[15:8], 1'b0, toggle, 1'b0, PGM_WORD[4],
                           readCount != 8'h00, toggle, PGM_WORD[1:0]}
              : {PGM_WORD[15:8], ~PGM_WORD[7], toggle,
                 failing && busyLeft == 8'h00, PGM_WORD[4:0]};
  assign dqIn = dqOe ? dqOut : (!pins.ceN && !pins.oeN) ? word : ~lastOut;
  assign readyBusy = !busy;
endmodule : fwsr_flash_model

// *** bench/tb_fwsr_host.sv ***
// Testbench for the flash status polling controller
`timescale 1ns/1ps
module tb_fwsr_host;
  localparam logic [15:0] PGM = 16'h00A5;
  logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready, arm, opFail, opErase;
  logic        awready, wready, bvalid, arready, rvalid, dqOe, readyBusy, irq;
  logic [7:0]  awaddr, araddr, opReads, readCount, resetSeen;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] dqOut, dqIn, lastWrite;
  fwsr_pkg::fwsr_pins_type flashPins;
  int          fail_count, checks_done, cycles;

  fwsr_host fwsr_host_inst (.clock(clock), .rst_n(rst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .flashPins(flashPins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
    .readyBusy(readyBusy), .irq(irq));
  fwsr_flash_model #(.PGM_WORD(PGM)) fwsr_flash_model_inst (.pins(flashPins),
    .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .readyBusy(readyBusy), .arm(arm),
    .opReads(opReads), .opFail(opFail), .opErase(opErase), .readCount(readCount),
    .resetSeen(resetSeen), .lastWrite(lastWrite));

  initial clock = 1'b0;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    bit awDone, wDone;
    awDone = 0;
    wDone = 0;
    @(posedge clock);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (awvalid && awready === 1'b1) begin awDone = 1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin wDone = 1; wvalid <= 1'b0; end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a);
    @(posedge clock);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic waitIrq(input int b);
    for (int n = 0; n < 400; n++) begin
      axiRead(fwsr_pkg::OFF_CTRL);
      if (rd[0] === 1'b0) begin
        axiRead(fwsr_pkg::OFF_IRQ);
        if (rd[b] === 1'b1) break;
      end
    end
    check({31'h0, rd[b]}, 32'h1);
  endtask : waitIrq

  task automatic startOp(input logic [7:0] n, input logic f, input logic e);
    @(posedge clock);
    opErase <= e;
    opReads <= n; opFail <= f; arm <= 1'b1;
    @(posedge clock);
    arm <= 1'b0;
  endtask : startOp

  task automatic testReset();
    axiRead(fwsr_pkg::OFF_MASK);
    check(rd, fwsr_pkg::RST_MASK);
    axiRead(fwsr_pkg::OFF_RESULT);
    check(rd, {30'h0, fwsr_pkg::RES_NONE});
    axiRead(8'h1C);
    check({30'h0, rr}, 32'h2);
    check({31'h0, irq}, 32'h0);
  endtask : testReset

  task automatic testPoll(input logic [7:0] n);
    startOp(n, 1'b0, 1'b0);
    axiWrite(fwsr_pkg::OFF_MASK, 32'h0);
    axiWrite(fwsr_pkg::OFF_ADDR, 32'h40);
    axiWrite(fwsr_pkg::OFF_CTRL, 32'h1 << fwsr_pkg::CTRL_POLL);
    waitIrq(fwsr_pkg::IRQ_DONE);
    check({31'h0, irq}, 32'h0);
    axiRead(fwsr_pkg::OFF_RESULT);
    check(rd, {30'h0, fwsr_pkg::RES_OK});
    axiRead(fwsr_pkg::OFF_DATA);
    check(rd, {16'h0, PGM});
    check({31'h0, readCount >= n + 8'h02}, 32'h1);
    axiRead(fwsr_pkg::OFF_STATUS);
    check({31'h0, rd[16]}, 32'h1);
    check({31'h0, rd[fwsr_pkg::BIT_WINDOW]}, {31'h0, PGM[fwsr_pkg::BIT_WINDOW]});
    axiWrite(fwsr_pkg::OFF_MASK, 32'h1 << fwsr_pkg::IRQ_DONE);
    @(posedge clock);
    check({31'h0, irq}, 32'h1);
    axiWrite(fwsr_pkg::OFF_IRQ, 32'h7);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
  endtask : testPoll

  task automatic testFail();
    startOp(8'h03, 1'b1, 1'b0);
    axiWrite(fwsr_pkg::OFF_MASK, 32'h1 << fwsr_pkg::IRQ_FAIL);
    axiWrite(fwsr_pkg::OFF_CTRL, 32'h1 << fwsr_pkg::CTRL_POLL);
    waitIrq(fwsr_pkg::IRQ_FAIL);
    check({31'h0, irq}, 32'h1);
    axiRead(fwsr_pkg::OFF_RESULT);
    check(rd, {30'h0, fwsr_pkg::RES_FAIL});
    check({24'h0, resetSeen}, 32'h1);
    check({16'h0, lastWrite}, {16'h0, fwsr_pkg::RESET_CMD});
    check({31'h0, readyBusy}, 32'h1);
    axiWrite(fwsr_pkg::OFF_IRQ, 32'h7);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
  endtask : testFail

  task automatic testSingle();
    axiWrite(fwsr_pkg::OFF_ADDR, 32'h123);
    axiWrite(fwsr_pkg::OFF_CTRL, 32'h1 << fwsr_pkg::CTRL_READ);
    waitIrq(fwsr_pkg::IRQ_BUS);
    axiRead(fwsr_pkg::OFF_DATA);
    check(rd, {16'h0, PGM});
    axiRead(fwsr_pkg::OFF_ADDR);
    check(rd, 32'h123);
    axiWrite(fwsr_pkg::OFF_IRQ, 32'h7);
    axiWrite(fwsr_pkg::OFF_DATA, 32'h1357);
    axiWrite(fwsr_pkg::OFF_CTRL, 32'h1 << fwsr_pkg::CTRL_WRITE);
    waitIrq(fwsr_pkg::IRQ_BUS);
    check({16'h0, lastWrite}, 32'h1357);
    axiWrite(fwsr_pkg::OFF_IRQ, 32'h7);
    axiWrite(fwsr_pkg::OFF_CTRL, 32'h1 << fwsr_pkg::CTRL_RESET);
    repeat (40) @(posedge clock);
    check({24'h0, resetSeen}, 32'h2);
    check({16'h0, lastWrite}, {16'h0, fwsr_pkg::RESET_CMD});
  endtask : testSingle

  task automatic testErase();
    startOp(8'h03, 1'b0, 1'b1);
    axiWrite(fwsr_pkg::OFF_MASK, 32'h0);
    axiWrite(fwsr_pkg::OFF_CTRL, 32'h1 << fwsr_pkg::CTRL_POLL);
    waitIrq(fwsr_pkg::IRQ_DONE);
    axiRead(fwsr_pkg::OFF_STATUS);
    check({31'h0, rd[fwsr_pkg::BIT_POLL]}, 32'h0);
    check({31'h0, rd[fwsr_pkg::BIT_WINDOW]}, 32'h1);
    axiRead(fwsr_pkg::OFF_DATA);
    check(rd, {16'h0, PGM});
    axiWrite(fwsr_pkg::OFF_IRQ, 32'h7);
  endtask : testErase

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, arm, opFail, opErase} = 8'h00;
    {awaddr, araddr, opReads} = 24'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    rst_n = 1'b0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    testReset();
    testPoll(8'h00);
    testPoll(8'h09);
    testFail();
    testSingle();
    testErase();
    end_of_test();
  end
endmodule : tb_fwsr_host

bind fwsr_host fwsr_host_sva fwsr_host_sva_inst (.clock(clock), .rst_n(rst_n),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .flashPins(flashPins), .dqOe(dqOe));
